//--- debug_wire_host.sv
// Notes on behaviour
// - every coded command opens with an 8-bit code; all fields go MSB first.
// - a delay lasts 16 debug clocks; the host sends nothing meanwhile.
// - E4 returns the 8-bit status/control value; C4 writes 8 control bits.
// - E0 sends address, delay, then target returns the byte read.
// - E1 sends address, delay, then target returns status then byte.
// - C0 sends address and data byte, then a delay for the store.
// - C1 sends address, data byte, delay, then target returns status.
// - E2 reads, C2 writes the 16-bit breakpoint match value, no delay.
// - 48/49 carry 8 bits, 4B/4C/4F carry 16 bits, each then a delay.
// - host sync holds low 128 slowest clocks, then speedup high, then release.
// - host times the 128-clock reply low and derives bit timing from it.
// - each bit is 16 debug clocks and starts with a host falling edge.
`timescale 1ns/1ps
module debug_wire_host #(
   parameter int SYNC_LOW_CYC = debug_pod_pkg::SYNC_LOW_CYC,
   parameter int SYNC_TMO_CYC = debug_pod_pkg::SYNC_TMO_CYC,
   parameter int DEF_TICK_DIV = debug_pod_pkg::DEF_TICK_DIV
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic cmdValid,
   output logic cmdReady,
   input wire logic cmdSync,
   input wire logic [debug_pod_pkg::CODE_W-1:0] cmdCode,
   input wire logic [debug_pod_pkg::ADDR_W-1:0] cmdAddr,
   input wire logic [debug_pod_pkg::DATA_W-1:0] cmdData,
   output logic rspValid,
   input wire logic rspReady,
   output logic [debug_pod_pkg::RSP_W-1:0] rspData,
   output logic busy,
   output logic [debug_pod_pkg::DIV_W-1:0] tickDiv,
   input wire logic wireIn,
   output logic wireOut,
   output logic wireOe
);
   import debug_pod_pkg::*;

   if (SYNC_LOW_CYC < 2 || SYNC_LOW_CYC >= 2 ** CNT_W || SYNC_TMO_CYC < 2 || SYNC_TMO_CYC >= 2 ** CNT_W
       || DEF_TICK_DIV < 1 || DEF_TICK_DIV >= 2 ** DIV_W) begin : g_bad_param
      $error("debug_wire_host: count parameter out of range");
   end

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0000,
      ST_SYNC_LOW = 4'b0001,
      ST_SYNC_UP = 4'b0010,
      ST_SYNC_WAITHI = 4'b0011,
      ST_SYNC_WAITLO = 4'b0100,
      ST_SYNC_MEAS = 4'b0101,
      ST_TX = 4'b0110,
      ST_DLY = 4'b0111,
      ST_RX = 4'b1000,
      ST_DONE = 4'b1001
   } state_t;

   localparam logic [CNT_W-1:0] LOW_END = CNT_W'(SYNC_LOW_CYC - 1);
   localparam logic [CNT_W-1:0] TMO_END = CNT_W'(SYNC_TMO_CYC - 1);

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   logic [1:0] wireSync_ff;
   state_t state_ff, nxt_state;
   logic [DIV_W-1:0] divCnt_ff, nxt_divCnt;
   logic [DIV_W-1:0] tickDiv_ff, nxt_tickDiv;
   logic [3:0] tickCnt_ff, nxt_tickCnt;
   logic [5:0] bitCnt_ff, nxt_bitCnt;
   logic [TX_W-1:0] txShift_ff, nxt_txShift;
   logic [RSP_W-1:0] rxShift_ff, nxt_rxShift;
   shape_t shape_ff, nxt_shape;
   logic [CNT_W-1:0] syncCnt_ff, nxt_syncCnt;
   logic wireOe_ff, nxt_wireOe;
   logic wireOut_ff, nxt_wireOut;

   stream_if #(.W(RSP_W)) bufIn ();
   stream_if #(.W(RSP_W)) bufOut ();

   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   wire wireLvl = wireSync_ff[1];
   wire accept = cmdValid && cmdReady;
   wire timed = (state_ff == ST_TX) || (state_ff == ST_DLY) || (state_ff == ST_RX);
   wire tickEn = timed && (divCnt_ff == tickDiv_ff - 16'h0001);
   wire bitEnd = tickEn && (tickCnt_ff == LAST_TICK);
   wire txBit = txShift_ff[TX_W-1];
   wire [3:0] lowTicks = txBit ? ONE_LOW : ZERO_LOW;
   wire lastTx = (bitCnt_ff == shape_ff.txLen - 6'h01);
   wire lastRx = (bitCnt_ff == shape_ff.rxLen - 6'h01);
   wire hasRx = (shape_ff.rxLen != FLD0);
   wire [CNT_W-1:0] measSum = syncCnt_ff + CNT_W'(ROUND_HALF);
   wire [DIV_W-1:0] measDiv = DIV_W'(measSum >> TICK_SHIFT);
   wire [DIV_W-1:0] newDiv = (measDiv == 16'h0000) ? 16'h0001 : measDiv;
   wire shape_t cmdShape = cmd_shape(cmdCode);
   // code leads, then address, then write data, all MSB first
   // code then fields
   wire [TX_W-1:0] txLoad =
      (cmdShape.lay == LAY_ADDR) ? {cmdCode, cmdAddr, cmdData[7:0], 8'h00} :
      (cmdShape.lay == LAY_WD16) ? {cmdCode, cmdData, 16'h0000} :
      (cmdShape.lay == LAY_WD8) ? {cmdCode, cmdData[7:0], 24'h000000} :
      {cmdCode, 32'h0000_0000};

   assign cmdReady = (state_ff == ST_IDLE);
   assign busy = (state_ff != ST_IDLE);
   assign tickDiv = tickDiv_ff;
   assign wireOut = wireOut_ff;
   assign wireOe = wireOe_ff;
   assign bufIn.valid = (state_ff == ST_DONE);
   assign bufIn.data = rxShift_ff;
   assign rspValid = bufOut.valid;
   assign rspData = bufOut.data;
   assign bufOut.ready = rspReady;

   // ---------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------
   always_comb begin
      nxt_state = state_ff;
      nxt_divCnt = (!timed || tickEn) ? 16'h0000 : divCnt_ff + 16'h0001;
      nxt_tickDiv = tickDiv_ff;
      nxt_tickCnt = tickCnt_ff;
      nxt_bitCnt = bitCnt_ff;
      nxt_txShift = txShift_ff;
      nxt_rxShift = rxShift_ff;
      nxt_shape = shape_ff;
      nxt_syncCnt = syncCnt_ff + 20'h00001;
      nxt_wireOe = wireOe_ff;
      nxt_wireOut = wireOut_ff;
      case (state_ff)
         ST_IDLE: begin
            nxt_syncCnt = 20'h00000;
            if (accept) begin
               nxt_wireOe = 1'b1;
               nxt_wireOut = 1'b0;
               nxt_rxShift = 24'h000000;
               if (cmdSync) begin
                  nxt_state = ST_SYNC_LOW;
               end else begin
                  nxt_state = ST_TX;
                  nxt_shape = cmdShape;
                  nxt_txShift = txLoad;
                  nxt_bitCnt = 6'h00;
                  nxt_tickCnt = 4'h0;
               end
            end
         end
         ST_SYNC_LOW: begin
            if (syncCnt_ff == LOW_END) begin
               nxt_wireOut = 1'b1;
               nxt_syncCnt = 20'h00000;
               nxt_state = ST_SYNC_UP;
            end
         end
         ST_SYNC_UP: begin
            nxt_wireOe = 1'b0;
            nxt_syncCnt = 20'h00000;
            nxt_state = ST_SYNC_WAITHI;
         end
         ST_SYNC_WAITHI: begin
            if (wireLvl) begin
               nxt_syncCnt = 20'h00000;
               nxt_state = ST_SYNC_WAITLO;
            end else if (syncCnt_ff == TMO_END) begin
               nxt_state = ST_DONE;
            end
         end
         ST_SYNC_WAITLO: begin
            if (!wireLvl) begin
               nxt_syncCnt = 20'h00001;
               nxt_state = ST_SYNC_MEAS;
            end else if (syncCnt_ff == TMO_END) begin
               nxt_state = ST_DONE;
            end
         end
         ST_SYNC_MEAS: begin
            if (wireLvl) begin
               nxt_tickDiv = newDiv;
               nxt_rxShift = RSP_W'(syncCnt_ff);
               nxt_state = ST_DONE;
            end else if (syncCnt_ff == TMO_END) begin
               nxt_state = ST_DONE;
            end
         end
         ST_TX: begin
            if (tickEn) begin
               nxt_tickCnt = tickCnt_ff + 4'h1;
               if (tickCnt_ff == lowTicks - 4'h1) begin
                  nxt_wireOut = 1'b1;
               end
               if (tickCnt_ff == lowTicks) begin
                  nxt_wireOe = 1'b0;
               end
               if (tickCnt_ff == LAST_TICK) begin
                  nxt_txShift = {txShift_ff[TX_W-2:0], 1'b0};
                  nxt_bitCnt = bitCnt_ff + 6'h01;
                  if (!lastTx) begin
                     nxt_wireOe = 1'b1;
                     nxt_wireOut = 1'b0;
                  end else if (shape_ff.hasDly) begin
                     nxt_bitCnt = 6'h00;
                     nxt_state = ST_DLY;
                  end else if (hasRx) begin
                     nxt_bitCnt = 6'h00;
                     nxt_wireOe = 1'b1;
                     nxt_wireOut = 1'b0;
                     nxt_state = ST_RX;
                  end else begin
                     nxt_state = ST_DONE;
                  end
               end
            end
         end
         ST_DLY: begin
            if (tickEn) begin
               nxt_tickCnt = tickCnt_ff + 4'h1;
               if (tickCnt_ff == LAST_TICK) begin
                  if (hasRx) begin
                     nxt_wireOe = 1'b1;
                     nxt_wireOut = 1'b0;
                     nxt_state = ST_RX;
                  end else begin
                     nxt_state = ST_DONE;
                  end
               end
            end
         end
         ST_RX: begin
            if (tickEn) begin
               nxt_tickCnt = tickCnt_ff + 4'h1;
               if (tickCnt_ff == RX_LOW - 4'h1) begin
                  nxt_wireOe = 1'b0;
               end
               if (tickCnt_ff == SAMPLE_TICK - 4'h1) begin
                  nxt_rxShift = {rxShift_ff[RSP_W-2:0], wireLvl};
               end
               if (tickCnt_ff == LAST_TICK) begin
                  nxt_bitCnt = bitCnt_ff + 6'h01;
                  if (lastRx) begin
                     nxt_state = ST_DONE;
                  end else begin
                     nxt_wireOe = 1'b1;
                     nxt_wireOut = 1'b0;
                  end
               end
            end
         end
         ST_DONE: begin
            if (bufIn.ready) begin
               nxt_state = ST_IDLE;
            end
         end
         default: begin
            nxt_state = ST_IDLE;
            nxt_wireOe = 1'b0;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         wireSync_ff <= 2'h3;
         state_ff <= ST_IDLE;
         divCnt_ff <= 16'h0000;
         tickDiv_ff <= DIV_W'(DEF_TICK_DIV);
         tickCnt_ff <= 4'h0;
         bitCnt_ff <= 6'h00;
         txShift_ff <= 40'h00_0000_0000;
         rxShift_ff <= 24'h000000;
         shape_ff <= '0;
         syncCnt_ff <= 20'h00000;
         wireOe_ff <= 1'b0;
         wireOut_ff <= 1'b0;
      end else begin
         wireSync_ff <= {wireSync_ff[0], wireIn};
         state_ff <= nxt_state;
         divCnt_ff <= nxt_divCnt;
         tickDiv_ff <= nxt_tickDiv;
         tickCnt_ff <= nxt_tickCnt;
         bitCnt_ff <= nxt_bitCnt;
         txShift_ff <= nxt_txShift;
         rxShift_ff <= nxt_rxShift;
         shape_ff <= nxt_shape;
         syncCnt_ff <= nxt_syncCnt;
         wireOe_ff <= nxt_wireOe;
         wireOut_ff <= nxt_wireOut;
      end
   end

   // results wait here so a stalled reader loses nothing
   two_entry_buf #(.W(RSP_W)) u_rspBuf (
      .clk(sys_clk),
      .nrst(nrst),
      .inp(bufIn),
      .outp(bufOut)
   );

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   logic [CNT_W-1:0] syncLowRun_ff;
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         syncLowRun_ff <= 20'h00000;
      end else if (state_ff == ST_IDLE) begin
         syncLowRun_ff <= 20'h00000;
      end else if (state_ff == ST_SYNC_LOW && wireOe_ff && !wireOut_ff) begin
         syncLowRun_ff <= syncLowRun_ff + 20'h00001;
      end
   end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!nrst);

   sequence s_speedup;
      wireOe_ff && wireOut_ff ##1 !wireOe_ff;
   endsequence
   sequence s_dly_end;
      state_ff == ST_DLY && bitEnd;
   endsequence

   a_code_first: assert property (accept && !cmdSync |=>
      state_ff == ST_TX && txShift_ff[TX_W-1:TX_W-8] == $past(cmdCode))
      else $error("command code not loaded first");
   a_msb_shift: assert property (state_ff == ST_TX && bitEnd && !lastTx |=>
      txShift_ff == ($past(txShift_ff) << 1))
      else $error("transmit bits not shifted MSB first");
   a_bit_start_low: assert property ((state_ff == ST_TX || state_ff == ST_RX)
      && tickCnt_ff == 4'h0 |-> wireOe_ff && !wireOut_ff)
      else $error("bit slot does not start with a low drive");
   a_delay_quiet: assert property (state_ff == ST_DLY |-> !wireOe_ff)
      else $error("wire driven during delay");
   a_delay_span: assert property (s_dly_end |=> state_ff != ST_DLY && tickCnt_ff == 4'h0)
      else $error("delay did not end after sixteen clocks");
   a_rx_release: assert property (state_ff == ST_RX && tickCnt_ff >= RX_LOW |-> !wireOe_ff)
      else $error("host still drives during target bit");
   a_tx_level: assert property (state_ff == ST_TX && tickCnt_ff == SAMPLE_TICK |->
      (wireOe_ff && !wireOut_ff) == !txBit)
      else $error("wire level wrong at target sample point");
   a_sync_hold: assert property (state_ff == ST_SYNC_UP |->
      syncLowRun_ff == CNT_W'(SYNC_LOW_CYC))
      else $error("sync low time wrong");
   a_sync_speedup: assert property ($rose(state_ff == ST_SYNC_UP) |-> s_speedup)
      else $error("sync speedup pulse missing");
   a_rate_learn: assert property (state_ff == ST_SYNC_MEAS && wireLvl |=>
      tickDiv_ff == $past(newDiv) && state_ff == ST_DONE)
      else $error("bit rate not taken from reply");
endmodule

//--- debug_pod_pkg.sv
package debug_pod_pkg;

   // ---------------------------------------------------------------
   // widths
   // ---------------------------------------------------------------
   localparam int CODE_W = 8;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 16;
   localparam int RSP_W = 24;
   localparam int TX_W = 40;
   localparam int CNT_W = 20;
   localparam int DIV_W = 16;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_NS = 25;
   localparam int SLOW_TCLK_NS = 16000;
   localparam int SYNC_LOW_TCLK = 128;
   localparam int SYNC_LOW_NS = SYNC_LOW_TCLK * SLOW_TCLK_NS;
   localparam int SYNC_LOW_CYC = (SYNC_LOW_NS + CLK_NS - 1) / CLK_NS;
   localparam int SYNC_TMO_CYC = 2 * SYNC_LOW_CYC;
   localparam int DEF_TICK_DIV = 10;
   // reply low time is 128 debug clocks: divide by 2**7, rounded
   localparam int TICK_SHIFT = 7;
   localparam int ROUND_HALF = 64;
   // debug-clock positions inside one 16-clock bit slot or delay
   localparam logic [3:0] LAST_TICK = 4'hF;
   localparam logic [3:0] SAMPLE_TICK = 4'hA;
   localparam logic [3:0] ZERO_LOW = 4'hD;
   localparam logic [3:0] ONE_LOW = 4'h4;
   localparam logic [3:0] RX_LOW = 4'h2;

   // ---------------------------------------------------------------
   // command codes
   // ---------------------------------------------------------------
   localparam logic [7:0] CMD_ACK_ON = 8'hD5;
   localparam logic [7:0] CMD_ACK_OFF = 8'hD6;
   localparam logic [7:0] CMD_HALT_REQ = 8'h90;
   localparam logic [7:0] CMD_STAT_RD = 8'hE4;
   localparam logic [7:0] CMD_CTRL_WR = 8'hC4;
   localparam logic [7:0] CMD_MEM_FETCH = 8'hE0;
   localparam logic [7:0] CMD_MEM_FETCH_STAT = 8'hE1;
   localparam logic [7:0] CMD_REFETCH = 8'hE8;
   localparam logic [7:0] CMD_MEM_STORE = 8'hC0;
   localparam logic [7:0] CMD_MEM_STORE_STAT = 8'hC1;
   localparam logic [7:0] CMD_MATCH_FETCH = 8'hE2;
   localparam logic [7:0] CMD_MATCH_STORE = 8'hC2;
   localparam logic [7:0] CMD_RESUME = 8'h08;
   localparam logic [7:0] CMD_SINGLE_STEP = 8'h10;
   localparam logic [7:0] CMD_RESUME_TAGGED = 8'h18;
   localparam logic [7:0] CMD_ACC_FETCH = 8'h68;
   localparam logic [7:0] CMD_FLAGS_FETCH = 8'h69;
   localparam logic [7:0] CMD_PROGCOUNT_FETCH = 8'h6B;
   localparam logic [7:0] CMD_INDEX_FETCH = 8'h6C;
   localparam logic [7:0] CMD_STACKPTR_FETCH = 8'h6F;
   localparam logic [7:0] CMD_INCR_FETCH = 8'h70;
   localparam logic [7:0] CMD_INCR_FETCH_STAT = 8'h71;
   localparam logic [7:0] CMD_ACC_STORE = 8'h48;
   localparam logic [7:0] CMD_FLAGS_STORE = 8'h49;
   localparam logic [7:0] CMD_PROGCOUNT_STORE = 8'h4B;
   localparam logic [7:0] CMD_INDEX_STORE = 8'h4C;
   localparam logic [7:0] CMD_STACKPTR_STORE = 8'h4F;
   localparam logic [7:0] CMD_INCR_STORE = 8'h50;
   localparam logic [7:0] CMD_INCR_STORE_STAT = 8'h51;

   // field lengths in bits
   localparam logic [5:0] FLD0 = 6'h00;
   localparam logic [5:0] FLD8 = 6'h08;
   localparam logic [5:0] FLD16 = 6'h10;
   localparam logic [5:0] FLD24 = 6'h18;
   localparam logic [5:0] FLD32 = 6'h20;

   // ---------------------------------------------------------------
   // command shape
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      LAY_NONE = 2'b00,
      LAY_WD8 = 2'b01,
      LAY_WD16 = 2'b10,
      LAY_ADDR = 2'b11
   } lay_t;

   typedef struct packed {
      lay_t lay;
      logic [5:0] txLen;
      logic hasDly;
      logic [5:0] rxLen;
   } shape_t;

   function automatic shape_t mk(input lay_t l, input logic [5:0] t, input logic d, input logic [5:0] r);
      shape_t s;
      s.lay = l;
      s.txLen = t;
      s.hasDly = d;
      s.rxLen = r;
      return s;
   endfunction

   // host-to-target bits, then the delay, then target-to-host bits
   function automatic shape_t cmd_shape(input logic [7:0] code);
      shape_t s;
      case (code)
         CMD_STAT_RD: s = mk(LAY_NONE, FLD8, 1'b0, FLD8);
         CMD_CTRL_WR: s = mk(LAY_WD8, FLD16, 1'b0, FLD0);
         CMD_MEM_FETCH: s = mk(LAY_ADDR, FLD24, 1'b1, FLD8);
         CMD_MEM_FETCH_STAT: s = mk(LAY_ADDR, FLD24, 1'b1, FLD16);
         CMD_REFETCH, CMD_MATCH_FETCH: s = mk(LAY_NONE, FLD8, 1'b0, FLD16);
         CMD_MEM_STORE: s = mk(LAY_ADDR, FLD32, 1'b1, FLD0);
         CMD_MEM_STORE_STAT: s = mk(LAY_ADDR, FLD32, 1'b1, FLD8);
         CMD_MATCH_STORE: s = mk(LAY_WD16, FLD24, 1'b0, FLD0);
         CMD_ACC_FETCH, CMD_FLAGS_FETCH, CMD_INCR_FETCH: s = mk(LAY_NONE, FLD8, 1'b1, FLD8);
         CMD_PROGCOUNT_FETCH, CMD_INDEX_FETCH, CMD_STACKPTR_FETCH,
         CMD_INCR_FETCH_STAT: s = mk(LAY_NONE, FLD8, 1'b1, FLD16);
         CMD_ACC_STORE, CMD_FLAGS_STORE, CMD_INCR_STORE: s = mk(LAY_WD8, FLD16, 1'b1, FLD0);
         CMD_INCR_STORE_STAT: s = mk(LAY_WD8, FLD16, 1'b1, FLD8);
         CMD_PROGCOUNT_STORE, CMD_INDEX_STORE,
         CMD_STACKPTR_STORE: s = mk(LAY_WD16, FLD24, 1'b1, FLD0);
         default: s = mk(LAY_NONE, FLD8, 1'b1, FLD0);
      endcase
      return s;
   endfunction

endpackage

//--- stream_if.sv
`timescale 1ns/1ps
interface stream_if #(parameter int W = 24) ();
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

//--- two_entry_buf.sv
`timescale 1ns/1ps
module two_entry_buf #(
   parameter int W = 24
) (
   input wire logic clk,
   input wire logic nrst,
   stream_if.snk inp,
   stream_if.src outp
);
   if (W < 1) begin : g_bad_width
      $error("two_entry_buf: width must be at least one");
   end

   logic [W-1:0] slot_ff [2];
   logic wrPtr_ff;
   logic rdPtr_ff;
   logic [1:0] fill_ff;

   wire push = inp.valid && inp.ready;
   wire pop = outp.valid && outp.ready;

   assign inp.ready = (fill_ff != 2'h2);
   assign outp.valid = (fill_ff != 2'h0);
   assign outp.data = slot_ff[rdPtr_ff];

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wrPtr_ff <= 1'b0;
         rdPtr_ff <= 1'b0;
         fill_ff <= 2'h0;
      end else begin
         wrPtr_ff <= wrPtr_ff ^ push;
         rdPtr_ff <= rdPtr_ff ^ pop;
         fill_ff <= fill_ff + {1'b0, push} - {1'b0, pop};
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         slot_ff[wrPtr_ff] <= inp.data;
      end
   end
endmodule

//--- debug_target_model.sv
`timescale 1ns/1ps
module debug_target_model #(
   parameter int T = 3,
   parameter int PERMIT = 7
) (
   input wire logic sys_clk,
   input wire logic dw,
   output logic tgtOe
);
   logic [7:0] mem [65536];
   logic [7:0] stat = 8'h00, acc = 8'h5A, c;
   logic [15:0] bkpt = 16'h0000, a, d;
   logic [15:0] lastA = 16'h0000, hx = 16'h0000;
   // host edges never lapse mid-command here, so no abort path is modelled
   logic halted = 1'b0;
   initial tgtOe = 1'b0;
   task automatic xfer(input int k, input logic [15:0] w, output logic [15:0] v);
      v = 16'h0000;
      for (int i = k - 1; i >= 0; i--) begin
         @(negedge dw);
         tgtOe = !w[i];
         repeat (10 * T) @(posedge sys_clk);
         v = {v[14:0], dw};
         repeat (3 * T) @(posedge sys_clk);
         tgtOe = 1'b0;
      end
   endtask
   always begin
      xfer(1, 16'hFFFF, a);
      c[7] = a[0];
      repeat (2 * T) @(posedge sys_clk);
      if (!dw) begin
         wait (dw);
         repeat (16 * T) @(posedge sys_clk);
         tgtOe = 1'b1;
         repeat (128 * T) @(posedge sys_clk);
         tgtOe = 1'b0;
      end else begin
         xfer(7, 16'hFFFF, a);
         c[6:0] = a[6:0];
         case (c)
            8'hE4: xfer(8, {8'h00, stat}, d);
            8'hC4: xfer(8, 16'hFFFF, {d[15:8], stat});
            8'hE0, 8'hE1: begin
               xfer(16, 16'hFFFF, a);
               lastA = a;
               xfer(c[0] ? 16 : 8, {stat, mem[a]}, d);
            end
            8'hE8: xfer(16, {stat, mem[lastA]}, d);
            8'h08, 8'h18: if (halted) halted = 1'b0;
            8'h10: ;
            8'h4C: begin
               xfer(16, 16'hFFFF, d);
               if (halted) hx = d;
            end
            8'h70, 8'h71: if (halted) begin
               hx++;
               xfer(c[0] ? 16 : 8, {stat, mem[hx]}, d);
            end
            8'h50, 8'h51: begin
               xfer(8, 16'hFFFF, d);
               if (halted) begin
                  hx++;
                  mem[hx] = d[7:0];
                  if (c[0]) xfer(8, {8'h00, stat}, d);
               end
            end
            8'hC0, 8'hC1: begin
               xfer(16, 16'hFFFF, a);
               xfer(8, 16'hFFFF, {d[15:8], mem[a]});
               if (c[0]) xfer(8, {8'h00, stat}, d);
            end
            8'hE2: xfer(16, bkpt, d);
            8'hC2: xfer(16, 16'hFFFF, bkpt);
            8'h90: halted = halted | stat[PERMIT];
            8'h68: if (halted) xfer(8, {8'h00, acc}, d);
            default: ;
         endcase
      end
   end
endmodule

//--- debug_wire_host_tb.sv
`timescale 1ns/1ps
module debug_wire_host_tb;
   import debug_pod_pkg::*;
   localparam logic [15:0] NIL = 16'h0000;
   logic sys_clk = 1'b0, nrst = 1'b0, cmdValid = 1'b0, cmdSync = 1'b0, rspReady = 1'b0;
   logic cmdReady, rspValid, wireOut, wireOe, tgtOe, dw, busy;
   logic [7:0] cmdCode = 8'h00;
   logic [15:0] cmdAddr = 16'h0000, cmdData = 16'h0000, tickDiv;
   logic [23:0] rspData, r;
   logic [31:0] lfsr = 32'hAAD8458D;
   int fail_count = 0, total_checks = 0, cycles = 0;
   assign dw = wireOe ? wireOut : ~tgtOe;
   initial forever #12.5 sys_clk = ~sys_clk;
   debug_wire_host #(.SYNC_LOW_CYC(200), .SYNC_TMO_CYC(2000), .DEF_TICK_DIV(4)) debug_wire_host_inst (
      .sys_clk(sys_clk), .nrst(nrst), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdSync(cmdSync),
      .cmdCode(cmdCode), .cmdAddr(cmdAddr), .cmdData(cmdData), .rspValid(rspValid), .rspReady(rspReady),
      .rspData(rspData), .busy(busy), .tickDiv(tickDiv), .wireIn(dw), .wireOut(wireOut), .wireOe(wireOe));
   debug_target_model #(.T(3), .PERMIT(7)) debug_target_model_inst (.sys_clk(sys_clk), .dw(dw), .tgtOe(tgtOe));
   function automatic logic [31:0] nxt(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   function automatic logic [23:0] rd_exp(input logic [7:0] st, input logic [7:0] b, input logic ws);
      return ws ? {8'h00, st, b} : {16'h0000, b};
   endfunction
   task automatic step();
      @(posedge sys_clk);
      #1;
   endtask
   task automatic chk(input string n, input logic [23:0] s, input logic [23:0] e);
      total_checks++;
      if (s !== e) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic get();
      rspReady = 1'b1;
      while (rspValid !== 1'b1) step();
      r = rspData;
      step();
      rspReady = 1'b0;
      step();
   endtask
   task automatic issue(input logic s, input logic [7:0] c, input logic [15:0] a, d, input logic w);
      cmdValid = 1'b1;
      cmdSync = s;
      cmdCode = c;
      cmdAddr = a;
      cmdData = d;
      while (cmdReady !== 1'b1) step();
      step();
      cmdValid = 1'b0;
      chk("busy", 24'(busy), 24'h1);
      if (w) get();
      else step();
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 100000) begin
         fail_count++;
         final_report();
      end
   end
   initial begin
      repeat (5) step();
      nrst = 1'b1;
      chk("reset div", 24'(tickDiv), 24'h4);
      issue(1'b1, 8'h00, NIL, NIL, 1'b1);
      chk("sync low", 24'(r > 24'd370 && r < 24'd400), 24'h1);
      chk("sync div", 24'(tickDiv), 24'h3);
      $display("test sync done");
      for (int p = 0; p < 2; p++) begin
         issue(1'b0, CMD_CTRL_WR, NIL, 16'(p * 128), 1'b1);
         issue(1'b0, CMD_STAT_RD, NIL, NIL, 1'b1);
         chk("status", r, 24'(p * 128));
         issue(1'b0, CMD_HALT_REQ, NIL, NIL, 1'b1);
         issue(1'b0, CMD_ACC_FETCH, NIL, NIL, 1'b1);
         chk("acc", r, p ? 24'h5A : 24'hFF);
      end
      $display("test halt done");
      for (int i = 0; i < 4; i++) begin
         lfsr = nxt(lfsr);
         issue(1'b0, i[0] ? CMD_MEM_STORE_STAT : CMD_MEM_STORE, lfsr[31:16], {8'h00, lfsr[7:0]}, 1'b1);
         chk("store", r, i[0] ? 24'h80 : 24'h0);
         issue(1'b0, i[0] ? CMD_MEM_FETCH_STAT : CMD_MEM_FETCH, lfsr[31:16], NIL, 1'b1);
         chk("fetch", r, rd_exp(8'h80, lfsr[7:0], i[0]));
      end
      issue(1'b0, CMD_REFETCH, NIL, NIL, 1'b1);
      chk("refetch", r, rd_exp(8'h80, lfsr[7:0], 1'b1));
      issue(1'b0, CMD_INDEX_STORE, NIL, lfsr[31:16] - 16'h0001, 1'b1);
      issue(1'b0, CMD_INCR_FETCH_STAT, NIL, NIL, 1'b1);
      chk("incr fetch", r, rd_exp(8'h80, lfsr[7:0], 1'b1));
      issue(1'b0, CMD_INCR_STORE, NIL, 16'h00C3, 1'b1);
      issue(1'b0, CMD_MEM_FETCH, lfsr[31:16] + 16'h0001, NIL, 1'b1);
      chk("incr store", r, 24'hC3);
      issue(1'b0, CMD_SINGLE_STEP, NIL, NIL, 1'b1);
      issue(1'b0, CMD_ACC_FETCH, NIL, NIL, 1'b1);
      chk("step acc", r, 24'h5A);
      issue(1'b0, CMD_RESUME, NIL, NIL, 1'b1);
      issue(1'b0, CMD_ACC_FETCH, NIL, NIL, 1'b1);
      chk("resumed acc", r, 24'hFF);
      $display("test memory done");
      issue(1'b0, CMD_MATCH_STORE, NIL, lfsr[15:0], 1'b1);
      issue(1'b0, 8'h77, NIL, NIL, 1'b1);
      chk("unknown", r, 24'h0);
      issue(1'b0, CMD_MATCH_FETCH, NIL, NIL, 1'b0);
      issue(1'b0, CMD_STAT_RD, NIL, NIL, 1'b0);
      issue(1'b0, CMD_MATCH_FETCH, NIL, NIL, 1'b0);
      get();
      chk("match", r, {8'h00, lfsr[15:0]});
      get();
      chk("status", r, 24'h80);
      get();
      chk("match", r, {8'h00, lfsr[15:0]});
      $display("test stall done");
      final_report();
   end
endmodule
